//--- include/fcc_cfg.svh
// Front end calibration config: offsets, field positions, reset values and codes.
// Assumes byte-wide register port with 8-bit addresses.
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH

// Register offsets
`define FCC_OFS_MASTER_GAIN     8'h00
`define FCC_OFS_MASTER_SINE_LO  8'h01
`define FCC_OFS_MASTER_SINE_HI  8'h02
`define FCC_OFS_INPUT_MODE      8'h0a
`define FCC_OFS_REF_SOURCE      8'h0b
`define FCC_OFS_SEGMENT_GAIN    8'h10
`define FCC_OFS_SEGMENT_SINE_LO 8'h11
`define FCC_OFS_SEGMENT_SINE_HI 8'h12
`define FCC_OFS_NONIUS_GAIN     8'h20
`define FCC_OFS_NONIUS_SINE_LO  8'h21
`define FCC_OFS_NONIUS_SINE_HI  8'h22

// Track bank decode: high nibble picks track, low nibble the byte in it
`define FCC_TRACK_STRIDE        4'h1
`define FCC_TRACK_BYTES         4'h3

// Input mode fields
`define FCC_KIND_BIT            0
`define FCC_RES_LSB             1
`define FCC_RES_MSB             2
`define FCC_DIV_BIT             3
`define FCC_POL_BIT             6

// Reference source field
`define FCC_REFSRC_LSB          3
`define FCC_REFSRC_MSB          4
`define FCC_REFSRC_INTERNAL     2'h0
`define FCC_REFSRC_RESERVED     2'h1
`define FCC_REFSRC_DRIVE_PIN    2'h2
`define FCC_REFSRC_EXTERNAL     2'h3

// Gain fields
`define FCC_COARSE_LSB          0
`define FCC_COARSE_MSB          2
`define FCC_COSFINE_LSB         3
`define FCC_COSFINE_MSB         7
`define FCC_SINEHI_MSB          2

// Mode codes
`define FCC_TRACK_NONE          2'h0
`define FCC_TRACK_MASTER        2'h1
`define FCC_TRACK_SEGMENT       2'h2
`define FCC_TRACK_NONIUS        2'h3
`define FCC_CAL_NORMAL          3'h0
`define FCC_CAL_OFFSET          3'h1
`define FCC_CAL_AMPLITUDE       3'h2
`define FCC_CAL_PHASE           3'h3

// Reset values
`define FCC_RST_BYTE            8'h00
`define FCC_RD_UNMAPPED         8'h00

`endif

//--- include/fcc_pkg.sv
// Front end calibration config: shared types.
// Assumes fcc_cfg.svh is available on the include path.
package fcc_pkg;

  typedef logic [1:0] fcc_track_code_t;
  typedef logic [2:0] fcc_cal_code_t;
  typedef logic [2:0] fcc_trk_vec_t;

  typedef enum {
    FCC_MODE_NORMAL,
    FCC_MODE_OFFSET,
    FCC_MODE_AMPLITUDE,
    FCC_MODE_PHASE,
    FCC_MODE_OTHER
  } fcc_cal_mode_t;

endpackage

//--- include/fcc_cal_if.sv
// Front end calibration config: link carrying select codes and synchronised comparator levels to the test mux.
// Assumes both ends share ref_clk.
`timescale 1ns/1ns
interface fcc_cal_if;
  import fcc_pkg::*;

  fcc_track_code_t track_code;
  fcc_cal_code_t   cal_code;
  fcc_trk_vec_t    cos_off;
  fcc_trk_vec_t    sin_off;
  fcc_trk_vec_t    amp;
  fcc_trk_vec_t    phase;
  logic            test_a;
  logic            test_b;
  logic            route_cal;
  fcc_track_code_t route_track;

  modport src (output track_code, cal_code, cos_off, sin_off, amp, phase,
               input test_a, test_b, route_cal, route_track);
  modport mux (input track_code, cal_code, cos_off, sin_off, amp, phase,
               output test_a, test_b, route_cal, route_track);
endinterface

//--- verilog/fcc_sync.sv
// Front end calibration config: three-flop synchroniser with agreement filter.
// Assumes inputs arrive asynchronous to ref_clk (analog comparators).
`timescale 1ns/1ns
module fcc_sync #(
  parameter int WIDTH = 12
) (
  input  wire logic             ref_clk,  // System clock
  input  wire logic             sys_rst,  // Sync reset, active high
  input  wire logic [WIDTH-1:0] async_in, // Raw asynchronous levels
  output logic      [WIDTH-1:0] sync_out  // Filtered synchronous levels
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Only stages two and three are compared; stage one may be metastable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          sync_out[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule

//--- verilog/fcc_cal_mux.sv
// Front end calibration config: test pin and line driver source selection.
// Assumes codes and comparator levels are already in the ref_clk domain.
`timescale 1ns/1ns
module fcc_cal_mux (
  input  wire logic ref_clk, // System clock
  input  wire logic sys_rst, // Sync reset, active high
  fcc_cal_if.mux    cal      // Codes in, test outputs back
);
  import fcc_pkg::*;

  `include "fcc_cfg.svh"

  function automatic fcc_cal_mode_t decode_mode(input fcc_track_code_t trk,
                                                input fcc_cal_code_t cal_c);
    fcc_cal_mode_t m;
    m = FCC_MODE_OTHER;
    if (trk == `FCC_TRACK_NONE) begin
      if (cal_c == `FCC_CAL_NORMAL) begin
        m = FCC_MODE_NORMAL;
      end
    end else begin
      unique case (cal_c)
        `FCC_CAL_OFFSET:    m = FCC_MODE_OFFSET;
        `FCC_CAL_AMPLITUDE: m = FCC_MODE_AMPLITUDE;
        `FCC_CAL_PHASE:     m = FCC_MODE_PHASE;
        default:            m = FCC_MODE_OTHER;
      endcase
    end
    return m;
  endfunction

  fcc_cal_mode_t mode;
  logic [1:0]    idx;

  assign mode = decode_mode(cal.track_code, cal.cal_code);
  assign idx  = cal.track_code - 2'h1;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cal.test_a <= 1'b0;
      cal.test_b <= 1'b0;
    end else begin
      unique case (mode)
        FCC_MODE_OFFSET: begin
          cal.test_a <= cal.cos_off[idx];
          cal.test_b <= cal.sin_off[idx];
        end
        FCC_MODE_AMPLITUDE: begin
          cal.test_a <= 1'b0;
          cal.test_b <= cal.amp[idx];
        end
        FCC_MODE_PHASE: begin
          cal.test_a <= 1'b0;
          cal.test_b <= cal.phase[idx];
        end
        FCC_MODE_NORMAL: begin
          cal.test_a <= 1'b0;
          cal.test_b <= 1'b0;
        end
        FCC_MODE_OTHER: begin
          cal.test_a <= 1'b0;
          cal.test_b <= 1'b0;
        end
      endcase
    end
  end

  // Line driver carries master in normal use, else the chosen track's signals
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cal.route_cal   <= 1'b0;
      cal.route_track <= `FCC_TRACK_MASTER;
    end else if (cal.track_code == `FCC_TRACK_NONE) begin
      cal.route_cal   <= 1'b0;
      cal.route_track <= `FCC_TRACK_MASTER;
    end else begin
      cal.route_cal   <= 1'b1;
      cal.route_track <= cal.track_code;
    end
  end

endmodule

//--- verilog/fcc_top.sv
// Front end calibration config: register bank, analog control fields and
// calibration test output selection for the three-track sine/cosine front end.
// Assumes a byte-wide register port driven by the serial or EEPROM loader on
// ref_clk, and comparator levels arriving asynchronously from analog.
`timescale 1ns/1ns
module fcc_top (
  input  wire logic                  ref_clk,                 // 20 MHz clock
  input  wire logic                  sys_rst,                 // Sync reset, high
  // Register port
  input  wire logic [7:0]            reg_addr,                // Byte address
  input  wire logic [7:0]            reg_wdata,               // Write data
  input  wire logic                  reg_wr,                  // Write strobe
  input  wire logic                  reg_rd,                  // Read strobe
  output logic      [7:0]            reg_rdata,               // Read data
  output logic                       reg_rvalid,              // Read data valid
  output logic                       reg_hit,                 // Last access mapped
  // Mode selection
  input  wire fcc_pkg::fcc_track_code_t track_select_code,   // Track select
  input  wire fcc_pkg::fcc_cal_code_t   calibration_select_code, // Cal select
  // Comparator levels, one bit per track: 0 master, 1 segment, 2 nonius
  input  wire fcc_pkg::fcc_trk_vec_t cosine_offset_compare,   // Cos offset comp
  input  wire fcc_pkg::fcc_trk_vec_t sine_offset_compare,     // Sine offset comp
  input  wire fcc_pkg::fcc_trk_vec_t amplitude_compare,       // Amplitude comp
  input  wire fcc_pkg::fcc_trk_vec_t phase_compare,           // Phase comp
  // Test pins and line driver routing
  output logic                       test_output_a,           // Test pin A
  output logic                       test_output_b,           // Test pin B
  output logic                       line_route_cal,          // Driver shows cal
  output fcc_pkg::fcc_track_code_t   line_route_track,        // Driver track
  // Shared input controls
  output logic                       input_kind_select,       // 1 voltage
  output logic                       current_polarity_select, // 1 positive
  output logic      [1:0]            input_resistance_select, // Current-mode R
  output logic                       divider_enable,          // Quarter divider
  output logic      [1:0]            reference_source_select, // Raw ref code
  output logic                       ref_use_internal,        // Internal ref
  output logic                       ref_drive_pin,           // Ref out to pin
  output logic                       ref_from_pin,            // Ref from pin
  // Per-track gain controls, index 0 master, 1 segment, 2 nonius
  output logic      [2:0]            coarse_gain_code [3],    // Coarse range
  output logic      [4:0]            cosine_fine_gain [3],    // Cosine fine
  output logic      [10:0]           sine_fine_gain   [3],    // Sine fine
  output logic      [2:0]            sine_gain_coarse [3],    // Sine path range
  output logic      [2:0]            cosine_gain_coarse [3]   // Cosine path range
);
  import fcc_pkg::*;

  `include "fcc_cfg.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Bank 0..2 by high nibble, byte 0..2 by low nibble
  function automatic logic track_hit(input logic [7:0] a);
    return (a[7:4] <= 4'h2) && (a[3:0] < `FCC_TRACK_BYTES);
  endfunction

  function automatic logic [1:0] track_of(input logic [7:0] a);
    return a[5:4];
  endfunction

  function automatic logic [1:0] byte_of(input logic [7:0] a);
    return a[1:0];
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return track_hit(a) || (a == `FCC_OFS_INPUT_MODE) || (a == `FCC_OFS_REF_SOURCE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] gain_ff [3][3];
  logic [7:0] input_mode_ff;
  logic [7:0] ref_source_ff;

  // Every byte holds its value until rewritten; no commit stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int t = 0; t < 3; t++) begin
        for (int b = 0; b < 3; b++) begin
          gain_ff[t][b] <= `FCC_RST_BYTE;
        end
      end
    end else if (reg_wr && track_hit(reg_addr)) begin
      gain_ff[track_of(reg_addr)][byte_of(reg_addr)] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      input_mode_ff <= `FCC_RST_BYTE;
    end else if (reg_wr && (reg_addr == `FCC_OFS_INPUT_MODE)) begin
      input_mode_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ref_source_ff <= `FCC_RST_BYTE;
    end else if (reg_wr && (reg_addr == `FCC_OFS_REF_SOURCE)) begin
      ref_source_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = `FCC_RD_UNMAPPED;
    if (track_hit(reg_addr)) begin
      nxt_rdata = gain_ff[track_of(reg_addr)][byte_of(reg_addr)];
    end else if (reg_addr == `FCC_OFS_INPUT_MODE) begin
      nxt_rdata = input_mode_ff;
    end else if (reg_addr == `FCC_OFS_REF_SOURCE) begin
      nxt_rdata = ref_source_ff;
    end
  end

  // One cycle read latency; unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata  <= `FCC_RD_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_hit <= 1'b0;
    end else if (reg_rd || reg_wr) begin
      reg_hit <= addr_mapped(reg_addr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared input controls

  always_comb begin
    input_kind_select       = input_mode_ff[`FCC_KIND_BIT];
    current_polarity_select = input_mode_ff[`FCC_POL_BIT];
    input_resistance_select = input_mode_ff[`FCC_RES_MSB:`FCC_RES_LSB];
    // Divider only acts on voltage inputs, so gate it by the input kind
    divider_enable          = input_mode_ff[`FCC_DIV_BIT] & input_kind_select;
  end

  always_comb begin
    reference_source_select = ref_source_ff[`FCC_REFSRC_MSB:`FCC_REFSRC_LSB];
    ref_use_internal        = 1'b1;
    ref_drive_pin           = 1'b0;
    ref_from_pin            = 1'b0;
    unique case (reference_source_select)
      // Reserved code falls back to the internal reference: safest choice
      `FCC_REFSRC_INTERNAL, `FCC_REFSRC_RESERVED: begin
        ref_use_internal = 1'b1;
      end
      `FCC_REFSRC_DRIVE_PIN: begin
        ref_drive_pin = 1'b1;
      end
      `FCC_REFSRC_EXTERNAL: begin
        ref_use_internal = 1'b0;
        ref_from_pin     = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-track gain controls

  always_comb begin
    for (int t = 0; t < 3; t++) begin
      coarse_gain_code[t] = gain_ff[t][0][`FCC_COARSE_MSB:`FCC_COARSE_LSB];
      cosine_fine_gain[t] = gain_ff[t][0][`FCC_COSFINE_MSB:`FCC_COSFINE_LSB];
      sine_fine_gain[t]   = {gain_ff[t][2][`FCC_SINEHI_MSB:0], gain_ff[t][1]};
      // Both paths share one coarse range; fine stage multiplies after it
      sine_gain_coarse[t]   = coarse_gain_code[t];
      cosine_gain_coarse[t] = coarse_gain_code[t];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration compare path

  logic [11:0] cmp_sync;

  fcc_sync #(
    .WIDTH (12)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({phase_compare, amplitude_compare, sine_offset_compare,
                cosine_offset_compare}),
    .sync_out (cmp_sync)
  );

  fcc_cal_if cal_link ();

  assign cal_link.track_code = track_select_code;
  assign cal_link.cal_code   = calibration_select_code;
  assign cal_link.cos_off    = cmp_sync[2:0];
  assign cal_link.sin_off    = cmp_sync[5:3];
  assign cal_link.amp        = cmp_sync[8:6];
  assign cal_link.phase      = cmp_sync[11:9];

  fcc_cal_mux u_mux (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cal     (cal_link.mux)
  );

  assign test_output_a    = cal_link.test_a;
  assign test_output_b    = cal_link.test_b;
  assign line_route_cal   = cal_link.route_cal;
  assign line_route_track = cal_link.route_track;

endmodule

//--- verif/fcc_top_checker.sv
// Checker: port assertions for the calibration config block.
// Assumes it is bound to fcc_top and every input moves on ref_clk.
`timescale 1ns/1ns
module fcc_top_checker
  import fcc_pkg::*;
(
  input wire logic                     ref_clk,                 // Clock
  input wire logic                     sys_rst,                 // Reset
  input wire logic [7:0]               reg_addr,                // Address
  input wire logic [7:0]               reg_wdata,               // Write data
  input wire logic                     reg_wr,                  // Write
  input wire logic                     reg_rd,                  // Read
  input wire logic [7:0]               reg_rdata,               // Read data
  input wire logic                     reg_rvalid,              // Read valid
  input wire logic                     reg_hit,                 // Mapped
  input wire fcc_pkg::fcc_track_code_t track_select_code,       // Track
  input wire fcc_pkg::fcc_cal_code_t   calibration_select_code, // Cal mode
  input wire fcc_pkg::fcc_trk_vec_t    cosine_offset_compare,   // Cos offset
  input wire fcc_pkg::fcc_trk_vec_t    sine_offset_compare,     // Sine offset
  input wire fcc_pkg::fcc_trk_vec_t    amplitude_compare,       // Amplitude
  input wire fcc_pkg::fcc_trk_vec_t    phase_compare,           // Phase
  input wire logic                     test_output_a,           // Pin A
  input wire logic                     test_output_b,           // Pin B
  input wire logic                     line_route_cal,          // Route cal
  input wire fcc_pkg::fcc_track_code_t line_route_track,        // Route track
  input wire logic                     input_kind_select,       // Kind
  input wire logic                     current_polarity_select, // Polarity
  input wire logic [1:0]               input_resistance_select, // Resistance
  input wire logic                     divider_enable,          // Divider
  input wire logic [1:0]               reference_source_select, // Ref code
  input wire logic                     ref_use_internal,        // Internal
  input wire logic                     ref_drive_pin,           // Drive pin
  input wire logic                     ref_from_pin,            // From pin
  input wire logic [2:0]               coarse_gain_code [3],    // Coarse
  input wire logic [4:0]               cosine_fine_gain [3],    // Cos fine
  input wire logic [10:0]              sine_fine_gain   [3]     // Sine fine
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Quiet count lets the comparator filter settle before pins are judged
  logic [13:0] watch;
  logic [3:0]  quiet_ff;
  logic [7:0]  last_addr_ff;
  logic [7:0]  last_wdata_ff;
  logic [1:0]  sel;
  assign watch = {track_select_code, calibration_select_code, cosine_offset_compare,
                  sine_offset_compare, amplitude_compare};
  assign sel = track_select_code - 2'h1;
  always_ff @(posedge ref_clk) begin
    last_addr_ff  <= reg_addr;
    last_wdata_ff <= reg_wdata;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || $changed(watch) || $changed(phase_compare)) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_unmapped_read: assert property (
    reg_rd && !(reg_addr inside {8'h00, 8'h01, 8'h02, 8'h0a, 8'h0b, 8'h10, 8'h11, 8'h12,
    8'h20, 8'h21, 8'h22}) |=> reg_rvalid && !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read not refused");
  a_gain_byte: assert property (
    reg_wr && reg_addr[3:0] == 4'h0 && reg_addr[7:4] < 4'h3 |=>
    {cosine_fine_gain[last_addr_ff[5:4]], coarse_gain_code[last_addr_ff[5:4]]} == last_wdata_ff)
    else $error("gain byte not applied");
  a_sine_fine: assert property (
    reg_wr && reg_addr[7:4] < 4'h3 && reg_addr[3:0] inside {4'h1, 4'h2} |=> (last_addr_ff[1] ?
    sine_fine_gain[last_addr_ff[5:4]][10:8] == last_wdata_ff[2:0] :
    sine_fine_gain[last_addr_ff[5:4]][7:0] == last_wdata_ff))
    else $error("sine fine gain not applied");
  a_input_mode: assert property (
    reg_wr && reg_addr == 8'h0a |=> {current_polarity_select, divider_enable,
    input_resistance_select, input_kind_select} ==
    {last_wdata_ff[6], last_wdata_ff[3] & last_wdata_ff[0], last_wdata_ff[2:0]})
    else $error("input mode fields wrong");
  a_ref_write: assert property (
    reg_wr && reg_addr == 8'h0b |=> reference_source_select == last_wdata_ff[4:3])
    else $error("reference code not applied");
  a_ref_decode: assert property (
    {ref_use_internal, ref_drive_pin, ref_from_pin} == (reference_source_select == 2'h3 ?
    3'h1 : (reference_source_select == 2'h2 ? 3'h6 : 3'h4)))
    else $error("reference decode wrong");
  a_fields_hold: assert property (
    !reg_wr |=> $stable({input_kind_select, current_polarity_select, input_resistance_select,
    divider_enable, reference_source_select}))
    else $error("input fields moved without a write");
  a_normal_mode: assert property (
    track_select_code == 2'h0 && calibration_select_code == 3'h0 |=>
    !test_output_a && !test_output_b && !line_route_cal && line_route_track == 2'h1)
    else $error("normal mode outputs wrong");
  a_track_route: assert property (
    track_select_code != 2'h0 |=> line_route_cal && line_route_track == $past(track_select_code))
    else $error("line driver track wrong");
  a_offset_pins: assert property (
    quiet_ff >= 4'h6 && $stable(watch) && track_select_code != 2'h0 &&
    calibration_select_code == 3'h1 |->
    test_output_a == cosine_offset_compare[sel] && test_output_b == sine_offset_compare[sel])
    else $error("offset mode pins wrong");
  a_amp_phase_pins: assert property (
    quiet_ff >= 4'h6 && $stable(watch) && $stable(phase_compare) && track_select_code != 2'h0
    && calibration_select_code inside {3'h2, 3'h3} |-> !test_output_a && test_output_b ==
    (calibration_select_code == 3'h2 ? amplitude_compare[sel] : phase_compare[sel]))
    else $error("amplitude or phase pins wrong");
endmodule

bind fcc_top fcc_top_checker u_chk (.*);

//--- verif/fcc_duty_meter.sv
// Partner model: calibration meter counting high cycles on both test pins.
// Assumes the pins are levels on ref_clk; clear restarts the window.
`timescale 1ns/1ns
module fcc_duty_meter (
  input  wire logic        ref_clk,       // Clock
  input  wire logic        clear,         // Restart window
  input  wire logic        test_output_a, // Pin A
  input  wire logic        test_output_b, // Pin B
  output logic      [15:0] high_a_ff,     // High cycles A
  output logic      [15:0] high_b_ff,     // High cycles B
  output logic      [15:0] span_ff        // Window cycles
);
  // Trim target is high count equal to half the span
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      high_a_ff <= 16'h0000;
      high_b_ff <= 16'h0000;
      span_ff   <= 16'h0000;
    end else begin
      high_a_ff <= high_a_ff + {15'h0000, test_output_a};
      high_b_ff <= high_b_ff + {15'h0000, test_output_b};
      span_ff   <= span_ff + 16'h0001;
    end
  end
endmodule

//--- verif/test_front_end_calibration_config.sv
// Testbench: register, field and calibration pin scenarios for fcc_top.
// Assumes the checker is bound to fcc_top and the meter watches the pins.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module test_front_end_calibration_config;
  import fcc_pkg::*;
  logic            ref_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, reg_hit, clear;
  logic            test_output_a, test_output_b, line_route_cal, input_kind_select;
  logic            current_polarity_select, divider_enable, ea, eb;
  logic            ref_use_internal, ref_drive_pin, ref_from_pin;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, d, g0;
  logic [1:0]      input_resistance_select, reference_source_select;
  logic [2:0]      m, x;
  logic [2:0]      coarse_gain_code [3], sine_gain_coarse [3], cosine_gain_coarse [3];
  logic [4:0]      cosine_fine_gain [3];
  logic [10:0]     sine_fine_gain [3];
  logic [15:0]     high_a_ff, high_b_ff, span_ff;
  fcc_track_code_t track_select_code, line_route_track;
  fcc_cal_code_t   calibration_select_code;
  fcc_trk_vec_t    cosine_offset_compare, sine_offset_compare, amplitude_compare;
  fcc_trk_vec_t    phase_compare;
  logic [7:0]      addrs [11] = '{8'h0a, 8'h0b, 8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12,
                                  8'h20, 8'h21, 8'h22};
  int              i, t, c, v, miscompares, checks_done;

  fcc_top dut (.*);
  fcc_duty_meter u_meter (.ref_clk, .clear, .test_output_a, .test_output_b, .high_a_ff,
    .high_b_ff, .span_ff);
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= wd;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] rdv);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid)
    rdv = reg_rdata;
  endtask
  // Six quiet cycles cover the four-edge comparator filter with margin
  task automatic cal_set(input logic [1:0] tc, input logic [2:0] cc, input logic [2:0] vc,
                         input logic [2:0] vs, input logic [2:0] va, input logic [2:0] vp);
    @(posedge ref_clk);
    track_select_code       <= tc;
    calibration_select_code <= cc;
    cosine_offset_compare   <= vc;
    sine_offset_compare     <= vs;
    amplitude_compare       <= va;
    phase_compare           <= vp;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #500000;
    miscompares++;
    final_report();
  end
  initial begin
    {sys_rst, clear, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h3, 18'h00000};
    {track_select_code, calibration_select_code} = 5'h00;
    {cosine_offset_compare, sine_offset_compare, amplitude_compare, phase_compare} = 12'h000;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK("reset_route", 4'h9, {ref_use_internal, line_route_cal, line_route_track})
    rd(8'h0a, d);
    `CHK("reset_mode", 8'h00, d)
    `CHK("hit", 1'b1, reg_hit)
    for (i = 0; i < 11; i++) wr(addrs[i], addrs[i] ^ 8'hc7);
    `CHK("mode_on", 5'h1d, {current_polarity_select, divider_enable, input_resistance_select,
      input_kind_select})
    for (i = 0; i < 11; i++) begin
      rd(addrs[i], d);
      `CHK("readback", addrs[i] ^ 8'hc7, d)
    end
    wr(8'h20, 8'hff);
    wr(8'h21, 8'hff);
    wr(8'h22, 8'h07);
    `CHK("top_codes", 19'h7_fff_f, {coarse_gain_code[2], cosine_fine_gain[2],
      sine_fine_gain[2]})
    for (i = 0; i < 2; i++) begin
      g0 = {i[3:0], 4'h0} ^ 8'hc7;
      `CHK("gain_byte", g0, {cosine_fine_gain[i], coarse_gain_code[i]})
      `CHK("sine_fine", {3'h5, g0 ^ 8'h01}, sine_fine_gain[i])
      `CHK("path_range", {2{g0[2:0]}}, {sine_gain_coarse[i], cosine_gain_coarse[i]})
    end
    wr(8'h0a, 8'h4c);
    `CHK("mode_div_cur", 5'h14, {current_polarity_select, divider_enable,
      input_resistance_select, input_kind_select})
    for (c = 0; c < 4; c++) begin
      wr(8'h0b, {3'h0, c[1:0], 3'h0});
      `CHK("ref", {c[1:0], (c == 3) ? 3'h1 : ((c == 2) ? 3'h6 : 3'h4)},
        {reference_source_select, ref_use_internal, ref_drive_pin, ref_from_pin})
    end
    wr(8'h03, 8'hff);
    `CHK("unmapped_wr", 1'b0, reg_hit)
    rd(8'h03, d);
    `CHK("unmapped_rd", 9'h000, {reg_hit, d})
    for (t = 1; t < 4; t++) for (c = 1; c < 5; c++) for (v = 0; v < 2; v++) begin
      m  = 3'h1 << (t - 1);
      x  = (v == 1) ? m : ~m;
      ea = (c == 1) && (v == 1);
      eb = (c == 2) ? (v == 1) : ((c != 4) && (v == 0));
      cal_set(2'(t), 3'(c), x, ~x, x, ~x);
      `CHK("pins", {ea, eb}, {test_output_a, test_output_b})
      `CHK("route", {1'b1, 2'(t)}, {line_route_cal, line_route_track})
    end
    cal_set(2'h0, 3'h0, 3'h7, 3'h7, 3'h7, 3'h7);
    `CHK("normal", 5'h01, {test_output_a, test_output_b, line_route_cal,
      line_route_track})
    cal_set(2'h2, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0);
    // Meter opens once step 0 has crossed the five-edge pin path
    for (i = 0; i < 69; i++) begin
      @(posedge ref_clk);
      clear               <= (i < 5);
      sine_offset_compare <= {1'b0, ~i[2], 1'b0};
    end
    @(posedge ref_clk);
    #1;
    `CHK("duty", 48'h0040_0020_0040, {high_a_ff, high_b_ff, span_ff})
    final_report();
  end
endmodule
